/* conv_model.sv */
// Behavioural temperature converter answering conversion requests
`default_nettype none
module conv_model #(
	parameter int LAT = 3
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Request side
	input wire logic convRequest,
	input wire logic [15:0] reading,
	// Answer side
	output logic convDone,
	output logic [15:0] convValue,
	output int nDone
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// Value only valid with the done pulse; toggles otherwise
	always @(posedge clk_sys) begin
		convDone <= 1'b0;
		convValue <= ~convValue;
		if (rst) begin
			cnt <= 0;
			nDone <= 0;
			convValue <= 16'hA5A5;
		end else if (convRequest) begin
			cnt <= LAT;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				convDone <= 1'b1;
				convValue <= reading;
				nDone <= nDone + 1;
			end
		end
	end
endmodule // conv_model
`default_nettype wire

/* logger_defs.svh */
// Register indices, field positions, reset values and timing counts of the mission logic
`ifndef LOGGER_DEFS_SVH
`define LOGGER_DEFS_SVH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_RTC_SECONDS 12'h200
`define IDX_SAMPLE_RATE 12'h206
`define IDX_ALARM_LOW 12'h208
`define IDX_ALARM_HIGH 12'h209
`define IDX_SENSOR_CTRL 12'h210
`define IDX_CLOCK_CONTROL 12'h212
`define IDX_MISSION_SETUP 12'h213
`define IDX_ALARM_FLAGS 12'h214
`define IDX_GENERAL_STATE 12'h215
`define IDX_START_DELAY 12'h216
`define IDX_TIMESTAMP 12'h219
`define IDX_SAMPLE_COUNT 12'h220
`define IDX_FUNC_CMD 12'h230
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CC_OSC_ENABLE 0
`define CC_SPEED_SELECT 1
`define MS_LOG_ENABLE 0
`define MS_LOG_FORMAT 2
`define MS_ALARM_START 5
`define SC_LOW_ENABLE 0
`define SC_HIGH_ENABLE 1
// ----------------------------------------
// Function command codes
// ----------------------------------------
`define CMD_START 8'hA1
`define CMD_STOP 8'hA2
`define CMD_CLEAR 8'hA3
`define CMD_FORCE 8'hA4
// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define LOG_BASE 17'h01000
`define RATE_RESET 16'h0001
`define SEC_PER_MIN 60
`define SEC_PERIOD_S 1
`define CLK_FREQ_HZ 25000000
`endif

/* logger_mission_control_regs.sv */
// Mission setup and status registers of the temperature logger, AHB-Lite slave
// Functional notes
// - speed bit: 0 counts minutes, 1 seconds
// - oscillator enable starts, clear stops clock
// - start command forces oscillator enable on
// - alarm-start mode logs only after an alarm
// - triggering sample logged, sample count unchanged
// - format bit selects 8 or 16-bit storage
// - 16-bit: high byte at lower address
// - logging enable arms; data from 1000h
// - alarm flags read-only, fixed bits 111/00
// - clear-memory command clears all alarm flags when no mission runs
// - battery reset flag set at reset, fail
// - high flag on reading >= high threshold
// - low flag on reading <= low threshold
// - forced conversion also updates alarm flags
// - triggering alarm also sets its flag
// - disabled alarm never sets a flag
// - status bits 0,2,5 show backup copy
// - start delay is 24-bit minute count
// - delay expires before alarm testing begins
// - delay register read-only during mission
// - timestamp read-only, captures clock at start
// - search match output when alarm recorded
// - start refused unless memory was cleared
// - running bit set during mission only
// - waiting bit cleared by alarm, not clear
// - setup bits 7 and 6 read as 1
`include "logger_defs.svh"
`default_nettype none
module logger_mission_control_regs
	import logger_pkg::*;
#(
	parameter int SEC_CYCLES = `CLK_FREQ_HZ * `SEC_PERIOD_S
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Temperature converter
	input wire logic convDone,
	input wire logic [15:0] convValue,
	output logic convRequest,
	output logic convWide,
	// Data-log memory write port
	output logic logWrite,
	output logic [16:0] logAddr,
	output logic [7:0] logData,
	// Pins and status
	input wire logic batteryFail,
	input wire logic pagesBackup,
	output logic searchMatch,
	output logic oscRunning
);

	typedef struct packed {
		phase_t phase;
		logic oscEnable;
		logic speedSelect;
		logic alarmStart;
		logic logFormat;
		logic logEnable;
		logic highEnable;
		logic lowEnable;
		logic [7:0] alarmLow;
		logic [7:0] alarmHigh;
		logic [15:0] sampleRate;
		logic [23:0] startDelay;
		logic [23:0] delayLeft;
		logic [31:0] timestamp;
		logic [23:0] sampleCount;
		logic batteryFlag;
		logic highFlag;
		logic lowFlag;
		logic memCleared;
		logic missionRun;
		logic waitAlarm;
		logic forcePending;
		logic [16:0] logPtr;
		logic lsbPending;
		logic [7:0] lsbByte;
		logic logWrite;
		logic [16:0] logAddr;
		logic [7:0] logData;
		logic convRequest;
		logic convWide;
		logic searchMatch;
		logic dpWrite;
		logic [11:0] dpIdx;
		logic [31:0] rdata;
		logic [1:0] battSync;
		logic [1:0] backupSync;
	} ctl_state_t;

	ctl_state_t s_r;
	ctl_state_t s_nxt;

	mission_tick_if tk ();

	mission_timebase #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_timebase (
		.clk_sys(clk_sys),
		.rst(rst),
		.tk(tk)
	);

	// ----------------------------------------
	// Register read decode
	// ----------------------------------------
	function automatic logic [31:0] readReg(input ctl_state_t s, input logic [11:0] idx,
		input logic [31:0] rtc);
		logic bk;
		bk = s.backupSync[1];
		case (idx)
			`IDX_RTC_SECONDS: readReg = rtc;
			`IDX_SAMPLE_RATE: readReg = {16'h0000, s.sampleRate};
			`IDX_ALARM_LOW: readReg = {24'h000000, s.alarmLow};
			`IDX_ALARM_HIGH: readReg = {24'h000000, s.alarmHigh};
			`IDX_SENSOR_CTRL: readReg = {30'h00000000, s.highEnable, s.lowEnable};
			`IDX_CLOCK_CONTROL: readReg = {30'h00000000, s.speedSelect, s.oscEnable};
			`IDX_MISSION_SETUP: readReg = {24'h000000, 2'b11, s.alarmStart, 1'b1, 1'b0,
				s.logFormat, 1'b0, s.logEnable};
			`IDX_ALARM_FLAGS: readReg = {24'h000000, s.batteryFlag, 3'b111, 2'b00,
				s.highFlag, s.lowFlag};
			`IDX_GENERAL_STATE: readReg = {24'h000000, 2'b11, bk, s.waitAlarm,
				s.memCleared, bk, s.missionRun, bk};
			`IDX_START_DELAY: readReg = {8'h00, s.startDelay};
			`IDX_TIMESTAMP: readReg = s.timestamp;
			`IDX_SAMPLE_COUNT: readReg = {8'h00, s.sampleCount};
			default: readReg = 32'h00000000;
		endcase
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	logic accept;
	logic wrEn;
	logic [7:0] cmd;
	logic [7:0] reading;
	logic forced;
	logic highHit;
	logic lowHit;
	logic testing;

	always_comb begin
		s_nxt = s_r;
		accept = 1'b0;
		wrEn = 1'b0;
		cmd = 8'h00;
		reading = convValue[15:8];
		forced = 1'b0;
		highHit = 1'b0;
		lowHit = 1'b0;
		testing = 1'b0;

		s_nxt.logWrite = 1'b0;
		s_nxt.convRequest = 1'b0;
		s_nxt.battSync = {s_r.battSync[0], batteryFail};
		s_nxt.backupSync = {s_r.backupSync[0], pagesBackup};

		// Bus address phase: capture write target, prepare read data
		accept = hsel && hready && htrans[1] && (hsize == 3'b010);
		s_nxt.dpWrite = accept && hwrite;
		s_nxt.dpIdx = haddr[13:2];
		if (accept && !hwrite) begin
			s_nxt.rdata = readReg(s_r, haddr[13:2], tk.rtcSeconds);
		end

		// Bus data phase: register writes, locked while a mission runs
		wrEn = s_r.dpWrite && !s_r.missionRun;
		if (wrEn) begin
			case (s_r.dpIdx)
				`IDX_SAMPLE_RATE: s_nxt.sampleRate = hwdata[15:0];
				`IDX_ALARM_LOW: s_nxt.alarmLow = hwdata[7:0];
				`IDX_ALARM_HIGH: s_nxt.alarmHigh = hwdata[7:0];
				`IDX_SENSOR_CTRL: begin
					s_nxt.highEnable = hwdata[`SC_HIGH_ENABLE];
					s_nxt.lowEnable = hwdata[`SC_LOW_ENABLE];
				end
				`IDX_CLOCK_CONTROL: begin
					s_nxt.oscEnable = hwdata[`CC_OSC_ENABLE];
					s_nxt.speedSelect = hwdata[`CC_SPEED_SELECT];
				end
				`IDX_MISSION_SETUP: begin
					s_nxt.alarmStart = hwdata[`MS_ALARM_START];
					s_nxt.logFormat = hwdata[`MS_LOG_FORMAT];
					s_nxt.logEnable = hwdata[`MS_LOG_ENABLE];
				end
				`IDX_START_DELAY: s_nxt.startDelay = hwdata[23:0];
				default: s_nxt.startDelay = s_nxt.startDelay;
			endcase
		end
		if (s_r.dpWrite && s_r.dpIdx == `IDX_FUNC_CMD) begin
			cmd = hwdata[7:0];
		end

		// Clear memory comes first so that any alarm in the same cycle wins
		if (cmd == `CMD_CLEAR && !s_r.missionRun) begin
			s_nxt.batteryFlag = 1'b0;
			s_nxt.highFlag = 1'b0;
			s_nxt.lowFlag = 1'b0;
			s_nxt.sampleCount = 24'h000000;
			s_nxt.timestamp = 32'h00000000;
			s_nxt.memCleared = 1'b1;
		end

		// Mission start and forced conversion
		if (cmd == `CMD_START && !s_r.missionRun && s_r.memCleared) begin
			s_nxt.missionRun = 1'b1;
			s_nxt.oscEnable = 1'b1;
			s_nxt.timestamp = tk.rtcSeconds;
			s_nxt.memCleared = 1'b0;
			s_nxt.logPtr = 17'h00000;
			s_nxt.delayLeft = s_r.startDelay;
			s_nxt.waitAlarm = s_r.alarmStart;
			s_nxt.phase = PH_DELAY;
		end
		if (cmd == `CMD_FORCE && !s_r.forcePending) begin
			s_nxt.forcePending = 1'b1;
			s_nxt.convRequest = 1'b1;
			s_nxt.convWide = 1'b1;
		end

		// Mission sequencing
		case (s_r.phase)
			PH_IDLE: begin
				s_nxt.phase = s_nxt.phase;
			end
			PH_DELAY: begin
				if (s_r.missionRun) begin
					if (s_r.delayLeft == 24'h000000) begin
						s_nxt.phase = s_r.alarmStart ? PH_WAIT : PH_LOG;
						s_nxt.convRequest = 1'b1;
						s_nxt.convWide = s_r.logFormat && !s_r.alarmStart;
					end else if (tk.minTick) begin
						s_nxt.delayLeft = s_r.delayLeft - 24'h000001;
					end
				end
			end
			PH_WAIT, PH_LOG: begin
				if (tk.sampleDue) begin
					s_nxt.convRequest = 1'b1;
					s_nxt.convWide = (s_r.phase == PH_LOG) && s_r.logFormat;
				end
			end
			default: s_nxt.phase = PH_IDLE;
		endcase

		// Conversion results: alarm tests and logging
		if (convDone) begin
			forced = s_r.forcePending;
			s_nxt.forcePending = 1'b0;
			testing = forced || (s_r.missionRun &&
				(s_r.phase == PH_WAIT || s_r.phase == PH_LOG));
			highHit = s_r.highEnable && (reading >= s_r.alarmHigh);
			lowHit = s_r.lowEnable && (reading <= s_r.alarmLow);
			if (testing) begin
				if (highHit) begin
					s_nxt.highFlag = 1'b1;
				end
				if (lowHit) begin
					s_nxt.lowFlag = 1'b1;
				end
			end
			if (!forced && s_r.missionRun) begin
				if (s_r.phase == PH_WAIT && (highHit || lowHit)) begin
					s_nxt.waitAlarm = 1'b0;
					s_nxt.phase = PH_LOG;
					s_nxt.logWrite = s_r.logEnable;
					s_nxt.logAddr = `LOG_BASE + s_r.logPtr;
					s_nxt.logData = reading;
					s_nxt.logPtr = s_r.logPtr + 17'h00001;
				end else if (s_r.phase == PH_LOG) begin
					s_nxt.sampleCount = s_r.sampleCount + 24'h000001;
					s_nxt.logWrite = s_r.logEnable;
					s_nxt.logAddr = `LOG_BASE + s_r.logPtr;
					s_nxt.logData = reading;
					if (s_r.logFormat) begin
						s_nxt.lsbPending = s_r.logEnable;
						s_nxt.lsbByte = convValue[7:0];
						s_nxt.logPtr = s_r.logPtr + 17'h00002;
					end else begin
						s_nxt.logPtr = s_r.logPtr + 17'h00001;
					end
				end
			end
		end else if (s_r.lsbPending) begin
			// Second byte of a wide reading goes to the next higher address
			s_nxt.lsbPending = 1'b0;
			s_nxt.logWrite = 1'b1;
			s_nxt.logAddr = s_r.logAddr + 17'h00001;
			s_nxt.logData = s_r.lsbByte;
		end

		// Stop is applied last so that no sequencing step can revive the phase
		if (cmd == `CMD_STOP && s_r.missionRun) begin
			s_nxt.missionRun = 1'b0;
			s_nxt.phase = PH_IDLE;
		end

		if (s_r.battSync[1]) begin
			s_nxt.batteryFlag = 1'b1;
		end
		s_nxt.searchMatch = s_nxt.batteryFlag || s_nxt.highFlag || s_nxt.lowFlag;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_r <= '0;
			s_r.phase <= PH_IDLE;
			s_r.sampleRate <= `RATE_RESET;
			s_r.batteryFlag <= 1'b1;
			s_r.searchMatch <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign tk.oscEnable = s_r.oscEnable;
	assign tk.speedSelect = s_r.speedSelect;
	assign tk.sampleRate = s_r.sampleRate;
	assign tk.sampleArm = s_r.missionRun && (s_r.phase == PH_WAIT || s_r.phase == PH_LOG);

	assign hrdata = s_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign convRequest = s_r.convRequest;
	assign convWide = s_r.convWide;
	assign logWrite = s_r.logWrite;
	assign logAddr = s_r.logAddr;
	assign logData = s_r.logData;
	assign searchMatch = s_r.searchMatch;
	assign oscRunning = s_r.oscEnable;

endmodule // logger_mission_control_regs
`default_nettype wire

/* logger_pkg.sv */
// Types shared by the mission control logic and its timebase
`default_nettype none
package logger_pkg;

	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001,
		PH_DELAY = 4'b0010,
		PH_WAIT = 4'b0100,
		PH_LOG = 4'b1000
	} phase_t;

	typedef struct packed {
		logic [31:0] rtcSec;
		logic [31:0] subSec;
		logic [5:0] minDiv;
		logic [15:0] rateCnt;
		logic secTick;
		logic minTick;
		logic sampleDue;
	} tb_state_t;

endpackage
`default_nettype wire

/* logger_regs_properties.sv */
// Concurrent checks on the ports of the mission control register block
`include "logger_defs.svh"
`default_nettype none
module logger_regs_properties #(
	parameter int SEC_CYCLES = 4
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Converter, log and status
	input wire logic convRequest,
	input wire logic logWrite,
	input wire logic [16:0] logAddr,
	input wire logic searchMatch
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Accepted word read of one register index
	sequence rdAt(logic [11:0] a);
		hsel && hready && htrans[1] && !hwrite && hsize == 3'b010 && haddr[13:2] == a;
	endsequence

	ready_const_a: assert property (hreadyout)
		else $error("slave inserted a wait state");
	resp_okay_a: assert property (!hresp)
		else $error("slave answered with an error");
	conv_pulse_a: assert property (convRequest |=> !convRequest)
		else $error("conversion request longer than one cycle");
	wide_pair_a: assert property (logWrite && $past(logWrite)
		|-> logAddr == $past(logAddr) + 17'h1)
		else $error("second log byte not at next address");
	reset_battery_a: assert property ($fell(rst) |-> searchMatch)
		else $error("battery flag not set after reset");
	flag_fixed_a: assert property (rdAt(`IDX_ALARM_FLAGS) |=> hrdata[6:2] == 5'b11100)
		else $error("alarm flags fixed bits wrong");
	setup_fixed_a: assert property (rdAt(`IDX_MISSION_SETUP) |=> hrdata[7:6] == 2'b11)
		else $error("setup upper bits not one");
	search_flags_a: assert property (rdAt(`IDX_ALARM_FLAGS)
		|=> searchMatch == (hrdata[7] | hrdata[1] | hrdata[0]))
		else $error("search match disagrees with alarm flags");
	unmapped_zero_a: assert property (rdAt(12'h3FF) |=> hrdata == 32'h00000000)
		else $error("unmapped read not zero");
endmodule // logger_regs_properties
`default_nettype wire

/* mission_tick_if.sv */
// Timebase signals between the mission control logic and its clock divider
`default_nettype none
interface mission_tick_if;
	logic oscEnable;
	logic speedSelect;
	logic sampleArm;
	logic [15:0] sampleRate;
	logic minTick;
	logic sampleDue;
	logic [31:0] rtcSeconds;

	modport timebase (
		input oscEnable, speedSelect, sampleArm, sampleRate,
		output minTick, sampleDue, rtcSeconds
	);
	modport control (
		output oscEnable, speedSelect, sampleArm, sampleRate,
		input minTick, sampleDue, rtcSeconds
	);
endinterface
`default_nettype wire

/* mission_timebase.sv */
// Real-time clock seconds, minute divider and sample rate counter
`include "logger_defs.svh"
`default_nettype none
module mission_timebase
	import logger_pkg::*;
#(
	parameter int SEC_CYCLES = `CLK_FREQ_HZ * `SEC_PERIOD_S
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Timebase link
	mission_tick_if.timebase tk
);

	tb_state_t s_r;
	tb_state_t s_nxt;
	logic unitTick;

	always_comb begin
		s_nxt = s_r;
		unitTick = 1'b0;
		s_nxt.secTick = 1'b0;
		s_nxt.minTick = 1'b0;
		s_nxt.sampleDue = 1'b0;
		// Nothing advances while the oscillator is stopped
		if (tk.oscEnable) begin
			if (s_r.subSec == 32'(SEC_CYCLES - 1)) begin
				s_nxt.subSec = 32'h0;
				s_nxt.secTick = 1'b1;
				s_nxt.rtcSec = s_r.rtcSec + 32'h1;
				if (s_r.minDiv == 6'(`SEC_PER_MIN - 1)) begin
					s_nxt.minDiv = 6'h0;
					s_nxt.minTick = 1'b1;
				end else begin
					s_nxt.minDiv = s_r.minDiv + 6'h1;
				end
			end else begin
				s_nxt.subSec = s_r.subSec + 32'h1;
			end
		end
		unitTick = tk.speedSelect ? s_nxt.secTick : s_nxt.minTick;
		if (!tk.sampleArm) begin
			s_nxt.rateCnt = 16'h0;
		end else if (unitTick) begin
			if (s_r.rateCnt + 16'h1 >= tk.sampleRate) begin
				s_nxt.rateCnt = 16'h0;
				s_nxt.sampleDue = 1'b1;
			end else begin
				s_nxt.rateCnt = s_r.rateCnt + 16'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tk.minTick = s_r.minTick;
	assign tk.sampleDue = s_r.sampleDue;
	assign tk.rtcSeconds = s_r.rtcSec;

endmodule // mission_timebase
`default_nettype wire

/* test_logger_mission_control_regs.sv */
// Self-checking testbench of the mission control registers
`include "logger_defs.svh"
`default_nettype none
module test_logger_mission_control_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp, convDone, convRequest, convWide;
	logic logWrite, batteryFail, pagesBackup, searchMatch, oscRunning;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] convValue, reading;
	logic [16:0] logAddr;
	logic [7:0] logData;
	int n_mismatch, checked, nDone;
	int cyc = 0;
	assign hready = hreadyout;

	logger_mission_control_regs #(.SEC_CYCLES(4)) u_logger_mission_control_regs (
		.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .convDone(convDone), .convValue(convValue),
		.convRequest(convRequest), .convWide(convWide), .logWrite(logWrite), .logAddr(logAddr),
		.logData(logData), .batteryFail(batteryFail), .pagesBackup(pagesBackup),
		.searchMatch(searchMatch), .oscRunning(oscRunning));
	conv_model u_conv_model (.clk_sys(clk_sys), .rst(rst), .convRequest(convRequest),
		.reading(reading), .convDone(convDone), .convValue(convValue), .nDone(nDone));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			finish_test;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single word transfer; read data lands in rdv
	task automatic xfer(input logic w, input logic [11:0] i, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {18'h0, i, 2'b00};
		hwrite <= w;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic rdChk(input logic [11:0] i, input logic [31:0] e);
		xfer(1'b0, i, 32'h0);
		chk(rdv, e);
	endtask

	task automatic cmd(input logic [7:0] c);
		xfer(1'b1, `IDX_FUNC_CMD, {24'h0, c});
	endtask

	task automatic forceConv(input logic [15:0] v);
		int n0;
		n0 = nDone;
		reading <= v;
		cmd(`CMD_FORCE);
		for (int k = 0; k < 50 && nDone == n0; k++) @(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic waitLog;
		for (int k = 0; k < 1000 && logWrite !== 1'b1; k++) @(posedge clk_sys);
	endtask

	task automatic t_reset;
		rdChk(`IDX_ALARM_FLAGS, 32'hF0);
		xfer(1'b1, `IDX_ALARM_FLAGS, 32'h0);
		rdChk(`IDX_ALARM_FLAGS, 32'hF0);
		xfer(1'b1, `IDX_MISSION_SETUP, 32'h0);
		rdChk(`IDX_MISSION_SETUP, 32'hD0);
		cmd(`CMD_START);
		rdChk(`IDX_GENERAL_STATE, 32'hC0);
		pagesBackup <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rdChk(`IDX_GENERAL_STATE, 32'hE5);
		pagesBackup <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rdChk(12'h3FF, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_alarm;
		xfer(1'b1, `IDX_SENSOR_CTRL, 32'h2);
		xfer(1'b1, `IDX_ALARM_HIGH, 32'h80);
		xfer(1'b1, `IDX_ALARM_LOW, 32'h40);
		forceConv(16'h3000);
		rdChk(`IDX_ALARM_FLAGS, 32'hF0);
		forceConv(16'h8000);
		rdChk(`IDX_ALARM_FLAGS, 32'hF2);
		xfer(1'b1, `IDX_SENSOR_CTRL, 32'h3);
		forceConv(16'h4000);
		rdChk(`IDX_ALARM_FLAGS, 32'hF3);
		cmd(`CMD_CLEAR);
		rdChk(`IDX_ALARM_FLAGS, 32'h70);
		batteryFail <= 1'b1;
		repeat (4) @(posedge clk_sys);
		batteryFail <= 1'b0;
		rdChk(`IDX_ALARM_FLAGS, 32'hF0);
		cmd(`CMD_CLEAR);
		rdChk(`IDX_GENERAL_STATE, 32'hC8);
		chk({31'h0, searchMatch}, 32'h0);
		$display("test alarm done");
	endtask

	task automatic t_mission;
		logic [31:0] ts;
		int t0;
		xfer(1'b1, `IDX_CLOCK_CONTROL, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, oscRunning}, 32'h0);
		xfer(1'b1, `IDX_CLOCK_CONTROL, 32'h1);
		repeat (12) @(posedge clk_sys);
		chk({31'h0, oscRunning}, 32'h1);
		// Oscillator off, seconds mode: the clock stays frozen until start
		xfer(1'b1, `IDX_CLOCK_CONTROL, 32'h2);
		xfer(1'b0, `IDX_RTC_SECONDS, 32'h0);
		ts = rdv;
		xfer(1'b1, `IDX_MISSION_SETUP, 32'h5);
		reading <= 16'h5A60;
		cmd(`CMD_START);
		waitLog;
		chk({15'h0, logAddr}, 32'h1000);
		chk({24'h0, logData}, 32'h5A);
		chk({31'h0, convWide}, 32'h1);
		@(posedge clk_sys);
		chk({15'h0, logAddr}, 32'h1001);
		chk({24'h0, logData}, 32'h60);
		chk({31'h0, oscRunning}, 32'h1);
		// Rate 1 in seconds: one sample per second of 4 cycles
		@(posedge clk_sys);
		waitLog;
		t0 = cyc;
		repeat (2) @(posedge clk_sys);
		waitLog;
		chk(32'(cyc - t0), 32'h4);
		rdChk(`IDX_TIMESTAMP, ts);
		rdChk(`IDX_GENERAL_STATE, 32'hC2);
		xfer(1'b1, `IDX_MISSION_SETUP, 32'h20);
		rdChk(`IDX_MISSION_SETUP, 32'hD5);
		xfer(1'b1, `IDX_START_DELAY, 32'h123);
		rdChk(`IDX_START_DELAY, 32'h0);
		cmd(`CMD_STOP);
		rdChk(`IDX_GENERAL_STATE, 32'hC0);
		$display("test mission done");
	endtask

	task automatic t_wait;
		cmd(`CMD_CLEAR);
		xfer(1'b1, `IDX_CLOCK_CONTROL, 32'h1);
		xfer(1'b1, `IDX_START_DELAY, 32'h1);
		rdChk(`IDX_START_DELAY, 32'h1);
		xfer(1'b1, `IDX_MISSION_SETUP, 32'h21);
		reading <= 16'h5000;
		cmd(`CMD_START);
		rdChk(`IDX_GENERAL_STATE, 32'hD2);
		repeat (20) @(posedge clk_sys);
		reading <= 16'h9000;
		waitLog;
		chk({15'h0, logAddr}, 32'h1000);
		chk({24'h0, logData}, 32'h90);
		chk({31'h0, convWide}, 32'h0);
		repeat (2) @(posedge clk_sys);
		rdChk(`IDX_ALARM_FLAGS, 32'h72);
		rdChk(`IDX_SAMPLE_COUNT, 32'h0);
		rdChk(`IDX_GENERAL_STATE, 32'hC2);
		cmd(`CMD_STOP);
		$display("test wait done");
	endtask

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		batteryFail = 1'b0;
		pagesBackup = 1'b0;
		reading = 16'h0;
		n_mismatch = 0;
		checked = 0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset;
		t_alarm;
		t_mission;
		t_wait;
		finish_test;
	end
endmodule // test_logger_mission_control_regs

bind logger_mission_control_regs logger_regs_properties #(.SEC_CYCLES(SEC_CYCLES))
	u_logger_regs_properties (
	.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.convRequest(convRequest), .logWrite(logWrite), .logAddr(logAddr),
	.searchMatch(searchMatch));
`default_nettype wire
